//--- fsp_pkg.sv
// Constants and carrier types for the flash segment protection map
package fsp_pkg;

   localparam int unsigned ADDR_W = 24;

   // Segment boundaries, program word addresses
   localparam logic [23:0] VEC_BASE     = 24'h000000;
   localparam logic [23:0] VEC_END      = 24'h0001FE;
   localparam logic [23:0] BOOT_BASE    = 24'h000200;
   localparam logic [23:0] BOOT_END_SML = 24'h0007FE;
   localparam logic [23:0] BOOT_END_MID = 24'h001FFE;
   localparam logic [23:0] BOOT_END_32K = 24'h003FFE;
   localparam logic [23:0] TOP_32K      = 24'h0057FE;
   localparam logic [23:0] TOP_16K      = 24'h002BFE;
   localparam logic [23:0] ADDR_STEP    = 24'h000002;

   // Segment sizes in instruction words
   localparam logic [15:0] VEC_IW       = 16'h0100;  // 256
   localparam logic [15:0] BOOT_IW_SML  = 16'h0300;  // 768
   localparam logic [15:0] BOOT_IW_MID  = 16'h0F00;  // 3840
   localparam logic [15:0] BOOT_IW_16K  = 16'h1500;  // 5376
   localparam logic [15:0] BOOT_IW_32K  = 16'h1F00;  // 7936
   localparam logic [15:0] GEN_IW_32K   = 16'h2B00;  // 11008
   localparam logic [15:0] GEN_IW_16K   = 16'h1500;  // 5376
   localparam logic [15:0] ZERO_IW      = 16'h0000;

   // Boot size select low-bit codes
   localparam logic [1:0] BSS_NONE = 2'h3;
   localparam logic [1:0] BSS_SML  = 2'h2;
   localparam logic [1:0] BSS_MID  = 2'h1;
   localparam logic [1:0] BSS_BIG  = 2'h0;

   // Debug channel select codes
   localparam logic [1:0] ICS_PAIR1 = 2'h3;
   localparam logic [1:0] ICS_PAIR2 = 2'h2;
   localparam logic [1:0] ICS_PAIR3 = 2'h1;
   localparam logic [1:0] ICS_RSVD  = 2'h0;

   // Debugger reserved data RAM
   localparam logic [15:0] DBG_RAM_BYTES = 16'h0050;  // 80

   localparam int unsigned NUM_PAIRS = 3;

   // Address class encoding
   typedef enum logic [1:0] {
      SEG_VECTOR  = 2'b00,
      SEG_BOOT    = 2'b01,
      SEG_GENERAL = 2'b10,
      SEG_UNIMPL  = 2'b11
   } fsp_seg_t;

   // Resolved segment map
   typedef struct packed {
      logic        boot_present;
      logic [23:0] boot_end;
      logic        gen_present;
      logic [23:0] gen_base;
      logic [23:0] top;
      logic [15:0] boot_iw;
      logic [15:0] gen_iw;
   } fsp_map_t;

   // Protection configuration words
   typedef struct packed {
      logic [7:0] boot_protect_config;
      logic [7:0] general_protect_config;
   } fsp_prot_t;

endpackage : fsp_pkg

//--- fsp_decode.sv
// Combinational address classifier against a resolved segment map
module fsp_decode
   import fsp_pkg::*;
(
   input  wire logic [23:0] i_addr,   // Program word address
   input  wire fsp_map_t    i_map,    // Resolved boundaries
   output fsp_seg_t         o_seg     // Segment class
);

   // Classify: above top first, then by ascending boundaries
   always_comb begin
      if (i_addr > i_map.top) begin
         o_seg = SEG_UNIMPL;
      end else if (i_addr <= VEC_END) begin
         o_seg = SEG_VECTOR;
      end else if (i_map.boot_present && i_addr <= i_map.boot_end) begin
         o_seg = SEG_BOOT;
      end else if (i_map.gen_present) begin
         o_seg = SEG_GENERAL;
      end else begin
         // Boot fills memory; nothing else left
         o_seg = SEG_BOOT;
      end
   end

endmodule : fsp_decode

//--- fsp_map.sv
// Flash segment protection map: boot size decode, address class, debug pins
module fsp_map
   import fsp_pkg::*;
#(
   parameter int unsigned PAIRS = NUM_PAIRS          // Pin pair count
) (
   input  wire logic             i_clk,                   // 50 MHz system clock
   input  wire logic             i_rst_n,                 // Async reset, low
   input  wire logic             i_mem_32k,               // 1 = 32 KB part
   input  wire logic [2:0]       i_boot_size_select,      // Boot size field
   input  wire fsp_prot_t        i_prot,                  // Protection words
   input  wire logic [23:0]      i_addr,                  // Address to classify
   input  wire logic [1:0]       i_debug_channel_select,  // Debug pair select
   input  wire logic             i_debug_enable,          // Debugger enabled
   input  wire logic             i_master_clear_pin_n,    // Master clear pin
   input  wire logic [PAIRS-1:0] i_prog_clock_pin,        // Clock pins
   input  wire logic [PAIRS-1:0] i_prog_data_pin,         // Data pins in
   input  wire logic             i_link_data_out,         // Debug data to send
   input  wire logic             i_link_data_oe_n,        // Debug data enable, low
   output fsp_seg_t              o_seg,                   // Address class
   output fsp_map_t              o_map,                   // Resolved map
   output fsp_prot_t             o_prot,                  // Latched protection
   output logic [PAIRS-1:0]      o_prog_data_pin,         // Data pins out
   output logic [PAIRS-1:0]      o_prog_data_oe_n,        // Data enables, low
   output logic                  o_link_clock,            // Selected clock, synced
   output logic                  o_link_data,             // Selected data, synced
   output logic                  o_prog_entry,            // Programming mode held
   output logic                  o_channel_err,           // Reserved select used
   output logic [15:0]           o_dbg_ram_bytes,         // Withheld RAM bytes
   output logic [PAIRS-1:0]      o_pin_reserved           // Pins withheld from app
);

   // Resolved map, registered
   fsp_map_t  map_q;
   fsp_map_t  next_map;
   fsp_prot_t prot_q;
   fsp_prot_t next_prot;

   // Compute map from boot size and memory size
   always_comb begin
      next_map              = '0;
      next_map.top          = i_mem_32k ? TOP_32K : TOP_16K;
      next_map.boot_present = 1'b1;
      next_map.gen_present  = 1'b1;
      case (i_boot_size_select[1:0])
         BSS_NONE: begin
            // No boot: general starts right after vectors
            next_map.boot_present = 1'b0;
            next_map.boot_end     = VEC_END;
            next_map.gen_base     = BOOT_BASE;
            next_map.boot_iw      = ZERO_IW;
            next_map.gen_iw       = i_mem_32k ? GEN_IW_32K : GEN_IW_16K;
         end
         BSS_SML: begin
            next_map.boot_end = BOOT_END_SML;
            next_map.gen_base = BOOT_END_SML + ADDR_STEP;
            next_map.boot_iw  = BOOT_IW_SML;
            next_map.gen_iw   = 16'((next_map.top - next_map.gen_base + ADDR_STEP) >> 1);
         end
         BSS_MID: begin
            next_map.boot_end = BOOT_END_MID;
            next_map.gen_base = BOOT_END_MID + ADDR_STEP;
            next_map.boot_iw  = BOOT_IW_MID;
            next_map.gen_iw   = 16'((next_map.top - next_map.gen_base + ADDR_STEP) >> 1);
         end
         BSS_BIG: begin
            if (i_mem_32k) begin
               next_map.boot_end = BOOT_END_32K;
               next_map.gen_base = BOOT_END_32K + ADDR_STEP;
               next_map.boot_iw  = BOOT_IW_32K;
               next_map.gen_iw   = 16'((TOP_32K - next_map.gen_base + ADDR_STEP) >> 1);
            end else begin
               // Boot runs to top; no general segment
               next_map.boot_end    = TOP_16K;
               next_map.gen_present = 1'b0;
               next_map.gen_base    = TOP_16K;
               next_map.boot_iw     = BOOT_IW_16K;
               next_map.gen_iw      = ZERO_IW;
            end
         end
         default: begin
            next_map.boot_present = 1'b0;
         end
      endcase
      // Only the two configuration words steer protection
      next_prot = i_prot;
   end

   // Register map and protection words
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         map_q  <= '0;
         prot_q <= '0;
      end else begin
         map_q  <= next_map;
         prot_q <= next_prot;
      end
   end

   assign o_map  = map_q;
   assign o_prot = prot_q;

   // Address classifier on registered map
   fsp_decode u_decode (
      .i_addr (i_addr),
      .i_map  (map_q),
      .o_seg  (o_seg)
   );

   // Pin synchronisers: three stages per clock, data pin
   logic [2:0] clk_sync [PAIRS];
   logic [2:0] dat_sync [PAIRS];
   logic [2:0] next_clk_sync [PAIRS];
   logic [2:0] next_dat_sync [PAIRS];
   logic [2:0] master_clear_pin_sync;
   logic [2:0] next_master_clear_pin_sync;
   logic [PAIRS-1:0] clk_lvl;   // Debounced levels
   logic [PAIRS-1:0] dat_lvl;
   logic [PAIRS-1:0] next_clk_lvl;
   logic [PAIRS-1:0] next_dat_lvl;
   logic             master_clear_pin_lvl;
   logic             next_master_clear_pin_lvl;

   // Per-pair shift and agreement check
   genvar g;
   generate
      for (g = 0; g < PAIRS; g++) begin : g_pair
         always_comb begin
            next_clk_sync[g] = {clk_sync[g][1:0], i_prog_clock_pin[g]};
            next_dat_sync[g] = {dat_sync[g][1:0], i_prog_data_pin[g]};
            // Change counts once stages two and three agree
            next_clk_lvl[g] = (clk_sync[g][1] == clk_sync[g][2]) ? clk_sync[g][2] : clk_lvl[g];
            next_dat_lvl[g] = (dat_sync[g][1] == dat_sync[g][2]) ? dat_sync[g][2] : dat_lvl[g];
         end
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               clk_sync[g] <= '0;
               dat_sync[g] <= '0;
               clk_lvl[g]  <= 1'b0;
               dat_lvl[g]  <= 1'b0;
            end else begin
               clk_sync[g] <= next_clk_sync[g];
               dat_sync[g] <= next_dat_sync[g];
               clk_lvl[g]  <= next_clk_lvl[g];
               dat_lvl[g]  <= next_dat_lvl[g];
            end
         end
      end
   endgenerate

   // Master clear synchroniser, reset to released level
   always_comb begin
      next_master_clear_pin_sync = {master_clear_pin_sync[1:0], i_master_clear_pin_n};
      next_master_clear_pin_lvl  = (master_clear_pin_sync[1] == master_clear_pin_sync[2]) ? master_clear_pin_sync[2] : master_clear_pin_lvl;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         master_clear_pin_sync <= 3'h7;
         master_clear_pin_lvl  <= 1'b1;
      end else begin
         master_clear_pin_sync <= next_master_clear_pin_sync;
         master_clear_pin_lvl  <= next_master_clear_pin_lvl;
      end
   end

   // Channel decode: one-hot pair select
   logic [PAIRS-1:0] pair_sel;
   logic             rsvd_sel;

   always_comb begin
      pair_sel = '0;
      rsvd_sel = 1'b0;
      case (i_debug_channel_select)
         ICS_PAIR1: pair_sel[0] = 1'b1;
         ICS_PAIR2: pair_sel[1] = 1'b1;
         ICS_PAIR3: pair_sel[2] = 1'b1;
         default:   rsvd_sel    = 1'b1;
      endcase
   end

   // Selected link and entry state, registered
   logic       link_clk_q;
   logic       link_dat_q;
   logic       entry_q;
   logic       next_link_clk;
   logic       next_link_dat;
   logic       next_entry;

   // Clock is always an input: the programmer drives it
   always_comb begin
      next_link_clk = |(clk_lvl & pair_sel);
      next_link_dat = |(dat_lvl & pair_sel);
      // Held master clear low marks the programming entry unless the reserved channel is selected
      next_entry    = ~master_clear_pin_lvl & ~rsvd_sel;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         link_clk_q <= 1'b0;
         link_dat_q <= 1'b0;
         entry_q    <= 1'b0;
      end else begin
         link_clk_q <= next_link_clk;
         link_dat_q <= next_link_dat;
         entry_q    <= next_entry;
      end
   end

   assign o_link_clock  = link_clk_q;
   assign o_link_data   = link_dat_q;
   assign o_prog_entry  = entry_q;
   assign o_channel_err = rsvd_sel;

   // Data drive only on the chosen pair; others float
   always_comb begin
      o_prog_data_pin  = {PAIRS{i_link_data_out}} & pair_sel;
      o_prog_data_oe_n = ~(pair_sel & {PAIRS{~i_link_data_oe_n}});
   end

   // Debugger resources withheld from application
   always_comb begin
      o_dbg_ram_bytes = i_debug_enable ? DBG_RAM_BYTES : ZERO_IW;
      o_pin_reserved  = i_debug_enable ? pair_sel : '0;
   end

   // Checks on map and pin behaviour
   a_vector_fixed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_addr <= VEC_END) && (i_addr <= map_q.top) |-> o_seg == SEG_VECTOR)
      else $error("vector address not classified as vector");
   // Past-cycle guard: the first edge after release still shows the reset map
   a_no_boot_32k: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $past(i_rst_n) && $past(i_boot_size_select[1:0]) == BSS_NONE && $past(i_mem_32k) |->
      !map_q.boot_present && map_q.gen_iw == GEN_IW_32K && map_q.top == TOP_32K)
      else $error("32K no-boot map wrong");
   a_small_boot: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $past(i_rst_n) && $past(i_boot_size_select[1:0]) == BSS_SML |->
      map_q.boot_end == BOOT_END_SML && map_q.boot_iw == BOOT_IW_SML)
      else $error("small boot segment wrong");
   a_mid_boot: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $past(i_rst_n) && $past(i_boot_size_select[1:0]) == BSS_MID |->
      map_q.boot_end == BOOT_END_MID && map_q.gen_base == 24'h002000)
      else $error("mid boot segment wrong");
   a_big_boot_16k: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $past(i_rst_n) && $past(i_boot_size_select[1:0]) == BSS_BIG && !$past(i_mem_32k) |->
      !map_q.gen_present && map_q.boot_iw == BOOT_IW_16K)
      else $error("16K big boot map wrong");
   a_top_16k: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $past(i_rst_n) && !$past(i_mem_32k) |-> map_q.top == TOP_16K)
      else $error("16K top wrong");
   a_gen_size_sml: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $past(i_rst_n) && $past(i_boot_size_select[1:0]) == BSS_SML && $past(i_mem_32k) |->
      map_q.gen_iw == 16'h2800 && map_q.gen_base == 24'h000800)
      else $error("32K general after small boot wrong");
   a_gen_size_big: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $past(i_rst_n) && $past(i_boot_size_select[1:0]) == BSS_BIG && $past(i_mem_32k) |->
      map_q.gen_iw == 16'h0C00 && map_q.gen_base == 24'h004000)
      else $error("32K general after big boot wrong");
   a_prot_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ##1 prot_q == $past(i_prot))
      else $error("protection words not latched");
   a_channel_rsvd: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_debug_channel_select == ICS_RSVD |-> o_channel_err && o_prog_data_oe_n == '1)
      else $error("reserved channel drove a pin");
   a_dbg_reserve: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_debug_enable && !rsvd_sel |-> o_dbg_ram_bytes == DBG_RAM_BYTES && $onehot(o_pin_reserved))
      else $error("debug resources not withheld");
   a_unimpl_top: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_addr > map_q.top |-> o_seg == SEG_UNIMPL)
      else $error("address above top not unimplemented");

endmodule : fsp_map

//--- fsp_prog_host.sv
// External programmer model driving every clock/data pin pair and master clear
module fsp_prog_host
   import fsp_pkg::*;
#(
   parameter int unsigned PAIRS = NUM_PAIRS   // Pin pair count
) (
   input  wire logic             i_clk,       // Bench clock
   input  wire logic             i_rst_n,     // Async reset, low
   input  wire logic [1:0]       i_pair,      // Pair index in use
   input  wire logic             i_active,    // Frame in progress
   input  wire logic             i_bit,       // Data level to send
   input  wire logic             i_enter,     // Request programming entry
   output logic [PAIRS-1:0]      o_clock,     // Clock pins
   output logic [PAIRS-1:0]      o_data,      // Data pins, host side
   output logic                  o_master_clear_pin_n     // Master clear pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // Clock stands still outside frames; idle data toggles so no stale level passes
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_clock  <= '0;
         o_data   <= '0;
         o_master_clear_pin_n <= 1'b1;
      end else begin
         for (int i = 0; i < PAIRS; i++) begin
            o_clock[i] <= i_active && (i == i_pair);
            o_data[i]  <= (i_active && (i == i_pair)) ? i_bit : ~o_data[i];
         end
         o_master_clear_pin_n <= ~i_enter;
      end
   end
endmodule : fsp_prog_host

//--- testbench.sv
// Self-checking bench for the flash segment protection map
module testbench;
   import fsp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

   // One expected map per configuration
   typedef struct packed {
      logic        m32;
      logic [2:0]  bss;
      logic        bp;
      logic [23:0] bend;
      logic [23:0] top;
      logic [15:0] biw;
      logic [15:0] giw;
   } fsp_row_t;

   localparam fsp_row_t ROWS [8] = '{
      '{1'b1, 3'h3, 1'b0, 24'h0001FE, 24'h0057FE, 16'h0000, 16'h2B00},
      '{1'b1, 3'h6, 1'b1, 24'h0007FE, 24'h0057FE, 16'h0300, 16'h2800},
      '{1'b1, 3'h1, 1'b1, 24'h001FFE, 24'h0057FE, 16'h0F00, 16'h1C00},
      '{1'b1, 3'h4, 1'b1, 24'h003FFE, 24'h0057FE, 16'h1F00, 16'h0C00},
      '{1'b0, 3'h7, 1'b0, 24'h0001FE, 24'h002BFE, 16'h0000, 16'h1500},
      '{1'b0, 3'h2, 1'b1, 24'h0007FE, 24'h002BFE, 16'h0300, 16'h1200},
      '{1'b0, 3'h5, 1'b1, 24'h001FFE, 24'h002BFE, 16'h0F00, 16'h0600},
      '{1'b0, 3'h0, 1'b1, 24'h002BFE, 24'h002BFE, 16'h1500, 16'h0000}};

   logic              i_clk = 1'b0;      // System clock
   logic              i_rst_n = 1'b0;    // Reset, low
   logic              mem32 = 1'b1;      // Part size
   logic [2:0]        bss = 3'h3;        // Boot size field
   fsp_prot_t         prot = '0;         // Protection words
   logic [23:0]       addr = '0;         // Address under test
   logic [1:0]        ics = 2'h3;        // Channel select
   logic              dbg_en = 1'b0;     // Debugger enable
   logic              lnk_out = 1'b0;    // Debug data to send
   logic              lnk_oe_n = 1'b1;   // Debug drive, low
   logic [1:0]        hpair = '0;        // Host pair index
   logic              hact = 1'b0;       // Host frame active
   logic              hbit = 1'b0;       // Host data bit
   logic              henter = 1'b0;     // Host entry request
   logic [2:0]        hclk, hdat, dout, doe_n, dwire, pres;
   logic              hmclr_n, lclk, ldat, entry, cerr;
   fsp_seg_t          seg;
   fsp_map_t          map;
   fsp_prot_t         oprot;
   logic [15:0]       rambytes;
   int                num_errors = 0;
   int                checks_done = 0;

   // Clock at 50 MHz
   always #10 i_clk = ~i_clk;

   // Device drives the wire only when its enable is low
   assign dwire = (~doe_n & dout) | (doe_n & hdat);

   fsp_map uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mem_32k(mem32), .i_boot_size_select(bss),
      .i_prot(prot), .i_addr(addr), .i_debug_channel_select(ics), .i_debug_enable(dbg_en),
      .i_master_clear_pin_n(hmclr_n), .i_prog_clock_pin(hclk), .i_prog_data_pin(dwire),
      .i_link_data_out(lnk_out), .i_link_data_oe_n(lnk_oe_n), .o_seg(seg), .o_map(map),
      .o_prot(oprot), .o_prog_data_pin(dout), .o_prog_data_oe_n(doe_n), .o_link_clock(lclk),
      .o_link_data(ldat), .o_prog_entry(entry), .o_channel_err(cerr),
      .o_dbg_ram_bytes(rambytes), .o_pin_reserved(pres));

   fsp_prog_host host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pair(hpair), .i_active(hact),
      .i_bit(hbit), .i_enter(henter), .o_clock(hclk), .o_data(hdat), .o_master_clear_pin_n(hmclr_n));

   // Verdict and end of run
   task automatic complete_run();
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   // Present an address and look at the class once it settles
   task automatic seg_at(input logic [23:0] a, input fsp_seg_t e);
      @(posedge i_clk);
      addr <= a;
      #1;
      `CHK(seg, e)
   endtask : seg_at

   // Run n edges, then settle
   task automatic edges(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : edges

   initial begin
      fsp_row_t r;
      logic [2:0] oh;
      // Reset held for ten cycles
      edges(5);
      `CHK(map, fsp_map_t'('0))
      `CHK(entry, 1'b0)
      edges(4);
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      // Ordinary cases: every boot size on both parts
      foreach (ROWS[k]) begin
         r = ROWS[k];
         @(posedge i_clk);
         mem32 <= r.m32;
         bss   <= r.bss;
         edges(2);
         `CHK(map.top, r.top)
         `CHK(map.boot_present, r.bp)
         `CHK(map.boot_iw, r.biw)
         `CHK(map.gen_present, (r.giw != 16'h0000))
         if (r.bp) begin
            `CHK(map.boot_end, r.bend)
         end
         if (r.giw != 16'h0000) begin
            `CHK(map.gen_iw, r.giw)
            `CHK(map.gen_base, r.bend + ADDR_STEP)
         end
         seg_at(24'h000000, SEG_VECTOR);
         seg_at(24'h0001FE, SEG_VECTOR);
         seg_at(24'h000200, r.bp ? SEG_BOOT : SEG_GENERAL);
         if (r.bp) begin
            seg_at(r.bend, SEG_BOOT);
         end
         seg_at(r.bend + ADDR_STEP, (r.giw != 16'h0000) ? SEG_GENERAL : SEG_UNIMPL);
         seg_at(r.top, (r.giw != 16'h0000) ? SEG_GENERAL : SEG_BOOT);
         seg_at(r.top + ADDR_STEP, SEG_UNIMPL);
      end
      // Protection words pass through
      @(posedge i_clk);
      prot <= 16'hA55A;
      edges(2);
      `CHK(oprot, 16'hA55A)
      @(posedge i_clk);
      // Each pin pair: debug reservation, drive and inbound sync
      dbg_en   <= 1'b1;
      lnk_oe_n <= 1'b0;
      lnk_out  <= 1'b1;
      for (int p = 0; p < 3; p++) begin
         oh = 3'h1 << p;
         @(posedge i_clk);
         ics   <= 2'h3 - p[1:0];
         hpair <= p[1:0];
         hact  <= 1'b1;
         hbit  <= p[0];
         edges(1);
         `CHK(pres, oh)
         `CHK(rambytes, DBG_RAM_BYTES)
         `CHK(doe_n, ~oh)
         `CHK(dout & oh, oh)
         @(posedge i_clk);
         lnk_oe_n <= 1'b1;
         edges(7);
         `CHK(lclk, 1'b1)
         `CHK(ldat, p[0])
         @(posedge i_clk);
         lnk_oe_n <= 1'b0;
         hact <= 1'b0;
      end
      // Master clear enters programming on a valid channel
      @(posedge i_clk);
      henter <= 1'b1;
      edges(7);
      `CHK(entry, 1'b1)
      // Reserved channel refused
      @(posedge i_clk);
      ics <= 2'h0;
      edges(3);
      `CHK(cerr, 1'b1)
      `CHK(doe_n, 3'h7)
      `CHK(entry, 1'b0)
      // Debug off frees the resources
      @(posedge i_clk);
      dbg_en <= 1'b0;
      ics    <= 2'h2;
      edges(1);
      `CHK(pres, 3'h0)
      `CHK(rambytes, 16'h0000)
      complete_run();
   end
endmodule : testbench
